// file: verilog/framer_global_register_decode.sv
// address decode, framer strobes and global register page behind an axi4-lite slave
`timescale 1ns/10ps
module framer_global_register_decode #(
  parameter logic [12:0] PART_NUMBER = 13'h0a5c, // arbitrary value
  parameter logic [2:0]  REVISION    = 3'h5      // arbitrary value
) (
  input  wire logic                                  aclk,
  input  wire logic                                  aresetn,
  input  wire logic [framer_global_pkg::AXI_ADDR_W-1:0] awaddr,
  input  wire logic                                  awvalid,
  output logic                                       awready,
  input  wire logic [31:0]                           wdata,
  input  wire logic [3:0]                            wstrb,
  input  wire logic                                  wvalid,
  output logic                                       wready,
  output logic [1:0]                                 bresp,
  output logic                                       bvalid,
  input  wire logic                                  bready,
  input  wire logic [framer_global_pkg::AXI_ADDR_W-1:0] araddr,
  input  wire logic                                  arvalid,
  output logic                                       arready,
  output logic [31:0]                                rdata,
  output logic [1:0]                                 rresp,
  output logic                                       rvalid,
  input  wire logic                                  rready,
  output logic [7:0]                                 fr_wr_en,
  output logic [7:0]                                 fr_wr_addr,
  output logic [15:0]                                fr_wdata,
  output logic [1:0]                                 fr_wstrb,
  output logic [7:0]                                 fr_rd_en,
  output logic [7:0]                                 fr_rd_addr,
  input  wire logic [127:0]                          fr_rdata,
  input  wire logic [7:0]                            framer_sync_int,
  input  wire logic [7:0]                            framer_line_int,
  input  wire logic [7:0]                            framer_elastic_int,
  input  wire logic [7:0]                            framer_hdlc_int,
  input  wire logic [63:0]                           stream_byte,
  input  wire logic [7:0]                            stream_valid,
  output logic [15:0]                                global_control_zero,
  output logic [15:0]                                global_control_one,
  output logic [15:0]                                framer_loopback_global,
  output logic                                       irq
);

  typedef enum logic [2:0] {
    R_IDLE  = 3'b001,
    R_FETCH = 3'b010,
    R_RESP  = 3'b100
  } rd_state_e;

  rd_state_e   rd_state;
  rd_state_e   next_rd_state;
  logic        aw_held;
  logic        w_held;
  logic        next_aw_held;
  logic        next_w_held;
  logic        next_bvalid;
  logic [11:0] aw_idx;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic [11:0] rd_idx;
  logic [15:0] rd_word;
  logic [15:0] vector_mask_low_framers;
  logic [15:0] vector_mask_high_framers;
  logic [15:0] analyser_interrupt_mask;
  logic [31:0] vec_status;
  logic [31:0] vec_mask;
  logic        analyser_full_flag;
  logic        full_q;
  logic        ana_clear;
  logic        do_write;
  logic        aw_ok;
  logic        w_ok;
  logic        ar_ok;
  logic [3:0]  wr_region;
  logic [3:0]  rd_region;
  logic [2:0]  src_sel;

  capture_if #(.DEPTH(framer_global_pkg::BUF_DEPTH)) cap ();

  capture_buffer #(
    .DEPTH (framer_global_pkg::BUF_DEPTH)
  ) u_buffer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cap     (cap.store)
  );

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // -------------------------------------------------------------------------
  // write channel: address and data taken in either order
  // -------------------------------------------------------------------------
  assign aw_ok        = awvalid && awready;
  assign w_ok         = wvalid && wready;
  assign do_write     = aw_held && w_held && !bvalid;
  assign next_aw_held = (aw_held || aw_ok) && !do_write;
  assign next_w_held  = (w_held || w_ok) && !do_write;
  assign next_bvalid  = do_write || (bvalid && !bready);
  assign wr_region    = aw_idx[11:8];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      bvalid  <= 1'b0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bresp   <= framer_global_pkg::RESP_OKAY;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      bvalid  <= next_bvalid;
      awready <= !next_aw_held && !next_bvalid;
      wready  <= !next_w_held && !next_bvalid;
      bresp   <= framer_global_pkg::RESP_OKAY;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_idx <= '0;
      w_data <= '0;
      w_strb <= '0;
    end
    else
    begin
      if (aw_ok)
        aw_idx <= awaddr[13:2];
      if (w_ok)
      begin
        w_data <= wdata;
        w_strb <= wstrb;
      end
    end
  end

  // -------------------------------------------------------------------------
  // framer write strobes
  // -------------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fr_wr_en   <= '0;
      fr_wr_addr <= '0;
      fr_wdata   <= '0;
      fr_wstrb   <= '0;
    end
    else
    begin
      fr_wr_en <= '0;
      if (do_write)
      begin
        if (!wr_region[3])
          fr_wr_en <= 8'h01 << wr_region[2:0];
        else if (wr_region == framer_global_pkg::REGION_BCAST)
          fr_wr_en <= 8'hff;
        fr_wr_addr <= aw_idx[7:0];
        fr_wdata   <= w_data[15:0];
        fr_wstrb   <= w_strb[1:0];
      end
    end
  end

  // -------------------------------------------------------------------------
  // global register page
  // -------------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      global_control_zero      <= framer_global_pkg::REG_RESET;
      global_control_one       <= framer_global_pkg::REG_RESET;
      vector_mask_low_framers  <= framer_global_pkg::REG_RESET;
      vector_mask_high_framers <= framer_global_pkg::REG_RESET;
      framer_loopback_global   <= framer_global_pkg::REG_RESET;
      analyser_interrupt_mask  <= framer_global_pkg::REG_RESET;
    end
    else if (do_write && wr_region == framer_global_pkg::REGION_GLOBAL)
    begin
      // status, id and buffer indices are not writable here
      case (aw_idx)
        framer_global_pkg::IDX_CTRL0:
          global_control_zero <= merge(global_control_zero, w_data, w_strb);
        framer_global_pkg::IDX_CTRL1:
          global_control_one <= merge(global_control_one, w_data, w_strb);
        framer_global_pkg::IDX_MASK_LOW:
          vector_mask_low_framers <= merge(vector_mask_low_framers, w_data, w_strb);
        framer_global_pkg::IDX_MASK_HIGH:
          vector_mask_high_framers <= merge(vector_mask_high_framers, w_data, w_strb);
        framer_global_pkg::IDX_LOOPBACK:
          framer_loopback_global <= merge(framer_loopback_global, w_data, w_strb);
        framer_global_pkg::IDX_ANA_MASK:
          analyser_interrupt_mask <= merge(analyser_interrupt_mask, w_data, w_strb);
        default:
          global_control_zero <= global_control_zero;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // vector status gathered per framer
  // -------------------------------------------------------------------------
  assign vec_mask = {vector_mask_high_framers, vector_mask_low_framers};

  for (genvar g = 0; g < framer_global_pkg::FRAMERS; g++)
  begin : g_vec
    assign vec_status[4*g+framer_global_pkg::VEC_SYNC] =
      framer_sync_int[g] && !vec_mask[4*g+framer_global_pkg::VEC_SYNC];
    assign vec_status[4*g+framer_global_pkg::VEC_LINE] =
      framer_line_int[g] && !vec_mask[4*g+framer_global_pkg::VEC_LINE];
    assign vec_status[4*g+framer_global_pkg::VEC_ELASTIC] =
      framer_elastic_int[g] && !vec_mask[4*g+framer_global_pkg::VEC_ELASTIC];
    assign vec_status[4*g+framer_global_pkg::VEC_HDLC] =
      framer_hdlc_int[g] && !vec_mask[4*g+framer_global_pkg::VEC_HDLC];
  end

  // -------------------------------------------------------------------------
  // analyser capture and full flag
  // -------------------------------------------------------------------------
  assign src_sel   = global_control_one[framer_global_pkg::CTRL1_SRC_LSB +: 3];
  assign ana_clear = do_write && aw_idx == framer_global_pkg::IDX_ANA_STAT
                     && w_strb[0] && w_data[framer_global_pkg::ANA_FULL_BIT];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cap.wr_byte  <= '0;
      cap.wr_valid <= 1'b0;
      cap.restart  <= 1'b1;
    end
    else
    begin
      cap.wr_byte  <= stream_byte[{src_sel, 3'h0} +: 8];
      cap.wr_valid <= stream_valid[src_sel]
                      && global_control_one[framer_global_pkg::CTRL1_CAP_EN];
      // clearing the full flag rearms the buffer for a new capture
      cap.restart  <= ana_clear;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      full_q             <= 1'b0;
      analyser_full_flag <= 1'b0;
    end
    else
    begin
      full_q <= cap.full;
      // a fill edge in the clearing cycle wins over the clear
      if (cap.full && !full_q)
        analyser_full_flag <= 1'b1;
      else if (ana_clear)
        analyser_full_flag <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= (|vec_status) || (analyser_full_flag && !analyser_interrupt_mask[0]);
  end

  // -------------------------------------------------------------------------
  // read channel
  // -------------------------------------------------------------------------
  assign ar_ok     = arvalid && arready;
  assign rd_region = rd_idx[11:8];
  assign cap.rd_index = rd_idx[$clog2(framer_global_pkg::BUF_DEPTH)-1:0];

  always_comb
  begin
    next_rd_state = rd_state;
    unique case (rd_state)
      R_IDLE:  if (ar_ok) next_rd_state = R_FETCH;
      R_FETCH: next_rd_state = R_RESP;
      R_RESP:  if (rready) next_rd_state = R_IDLE;
    endcase
  end

  always_comb
  begin
    rd_word = '0;
    if (!rd_region[3])
      rd_word = fr_rdata[{rd_region[2:0], 4'h0} +: 16];
    else if (rd_region == framer_global_pkg::REGION_GLOBAL)
    begin
      case (rd_idx)
        framer_global_pkg::IDX_CTRL0:     rd_word = global_control_zero;
        framer_global_pkg::IDX_CTRL1:     rd_word = global_control_one;
        framer_global_pkg::IDX_MASK_LOW:  rd_word = vector_mask_low_framers;
        framer_global_pkg::IDX_MASK_HIGH: rd_word = vector_mask_high_framers;
        framer_global_pkg::IDX_LOOPBACK:  rd_word = framer_loopback_global;
        framer_global_pkg::IDX_ANA_MASK:  rd_word = analyser_interrupt_mask;
        framer_global_pkg::IDX_VEC_LOW:   rd_word = vec_status[15:0];
        framer_global_pkg::IDX_VEC_HIGH:  rd_word = vec_status[31:16];
        framer_global_pkg::IDX_ID:        rd_word = {PART_NUMBER, REVISION};
        framer_global_pkg::IDX_ANA_STAT:  rd_word = {15'h0000, analyser_full_flag};
        default:
          if (rd_idx >= framer_global_pkg::IDX_BUF_FIRST
              && rd_idx <= framer_global_pkg::IDX_BUF_LAST)
            rd_word = {8'h00, cap.rd_byte};
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_state   <= R_IDLE;
      arready    <= 1'b0;
      rvalid     <= 1'b0;
      rdata      <= '0;
      rresp      <= framer_global_pkg::RESP_OKAY;
      rd_idx     <= '0;
      fr_rd_en   <= '0;
      fr_rd_addr <= '0;
    end
    else
    begin
      rd_state <= next_rd_state;
      arready  <= next_rd_state == R_IDLE;
      rresp    <= framer_global_pkg::RESP_OKAY;
      fr_rd_en <= '0;
      if (ar_ok)
      begin
        rd_idx     <= araddr[13:2];
        fr_rd_addr <= araddr[9:2];
        if (!araddr[13])
          fr_rd_en <= 8'h01 << araddr[12:10];
      end
      if (rd_state == R_FETCH)
      begin
        rdata  <= {16'h0000, rd_word};
        rvalid <= 1'b1;
      end
      else if (rd_state == R_RESP && rready)
        rvalid <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence both_taken_s;
    aw_held && w_held && !bvalid;
  endsequence

  sequence resp_given_s;
    ##1 bvalid ##[0:1000] bready;
  endsequence

  write_resp_a: assert property (both_taken_s |-> resp_given_s)
    else $error("write response missing after address and data");

  elastic_vec_a: assert property (vec_status[18] ==
    (framer_elastic_int[4] && !vector_mask_high_framers[2]))
    else $error("framer 4 elastic vector wrong");

  line_vec_a: assert property (vector_mask_high_framers[1] |-> !vec_status[17])
    else $error("masked framer 4 line vector is high");

  sync_vec_a: assert property (framer_sync_int[4] && !vector_mask_high_framers[0]
    |-> vec_status[16])
    else $error("framer 4 sync vector not set");

  id_read_a: assert property (rd_state == R_FETCH && rd_idx == framer_global_pkg::IDX_ID
    |=> rdata == {16'h0000, PART_NUMBER, REVISION} && rvalid)
    else $error("identification_revision read wrong");

  full_set_a: assert property (cap.full && !full_q |=> analyser_full_flag)
    else $error("full flag not set on buffer fill");

  framer_sel_a: assert property (do_write && !wr_region[3]
    |=> fr_wr_en == (8'h01 << $past(wr_region[2:0])) && fr_wr_addr == $past(aw_idx[7:0]))
    else $error("framer write strobe wrong");

  broadcast_a: assert property (do_write && wr_region == framer_global_pkg::REGION_BCAST
    |=> fr_wr_en == 8'hff)
    else $error("broadcast write did not reach all framers");

  ro_status_a: assert property (do_write && aw_idx == framer_global_pkg::IDX_ID
    |=> $stable(global_control_zero) && $stable(vector_mask_high_framers))
    else $error("read only write changed a register");

  ana_mask_a: assert property (analyser_full_flag && analyser_interrupt_mask[0]
    && vec_status == '0 |=> !irq)
    else $error("masked analyser flag raised interrupt");

  unmapped_a: assert property (rd_state == R_FETCH && rd_idx[11:8] > 4'h9
    |=> rdata == 32'h00000000)
    else $error("unused address read not zero");
endmodule

// file: verilog/framer_global_pkg.sv
// constants, register map and field layout of the framer global register decode
//
// Summary of operation
// - framer 4 elastic vector bit mirrors its elastic interrupt, held low when masked
// - framer 4 receive line vector bit mirrors its line interrupt, held low when masked
// - framer 4 sync vector bit mirrors its sync interrupt, held low when masked
// - identification_revision is read only: part number high thirteen bits, revision low three
// - analyser status bit zero sets once the capture buffer fills; other bits zero
// - capture buffer spans consecutive addresses, byte in low eight bits, first lowest
// - analyser captures from the stream of any of the eight framers
// - upper nibble 0 to 7 selects a framer, lower byte the register inside it
// - upper nibble 8 writes the addressed register in all eight framers at once
// - upper nibble 9 reaches one shared set of global registers and the buffer
// - control, mask and loopback registers read/write; vector status and id read only
// - analyser interrupt has its own mask register apart from its status register
package framer_global_pkg;

  localparam int          FRAMERS       = 8;
  localparam int          BUF_DEPTH     = 32;
  localparam int          AXI_ADDR_W    = 14;

  // register indices; the byte address is four times the index
  localparam logic [11:0] IDX_CTRL0     = 12'h900;
  localparam logic [11:0] IDX_CTRL1     = 12'h901;
  localparam logic [11:0] IDX_MASK_LOW  = 12'h902;
  localparam logic [11:0] IDX_MASK_HIGH = 12'h903;
  localparam logic [11:0] IDX_LOOPBACK  = 12'h904;
  localparam logic [11:0] IDX_ANA_MASK  = 12'h905;
  localparam logic [11:0] IDX_VEC_LOW   = 12'h910;
  localparam logic [11:0] IDX_VEC_HIGH  = 12'h911;
  localparam logic [11:0] IDX_ID        = 12'h912;
  localparam logic [11:0] IDX_ANA_STAT  = 12'h913;
  localparam logic [11:0] IDX_BUF_FIRST = 12'h920;
  localparam logic [11:0] IDX_BUF_LAST  = 12'h93f;

  localparam logic [3:0]  REGION_BCAST  = 4'h8;
  localparam logic [3:0]  REGION_GLOBAL = 4'h9;

  // vector status bit order inside each framer nibble
  localparam int          VEC_SYNC      = 0;
  localparam int          VEC_LINE      = 1;
  localparam int          VEC_ELASTIC   = 2;
  localparam int          VEC_HDLC      = 3;

  // capture control fields of global_control_one and the full bit of analyser status
  localparam int          CTRL1_SRC_LSB = 0;
  localparam int          CTRL1_CAP_EN  = 3;
  localparam int          ANA_FULL_BIT  = 0;

  localparam logic [15:0] REG_RESET     = 16'h0000;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;

endpackage

// file: verilog/capture_if.sv
// carrier between the register decode and the analyser capture buffer
`timescale 1ns/10ps
interface capture_if #(
  parameter int DEPTH = 32
);
  logic [7:0]               wr_byte;
  logic                     wr_valid;
  logic                     restart;
  logic                     full;
  logic [$clog2(DEPTH)-1:0] rd_index;
  logic [7:0]               rd_byte;

  modport owner (output wr_byte, wr_valid, restart, rd_index, input full, rd_byte);
  modport store (input wr_byte, wr_valid, restart, rd_index, output full, rd_byte);
endinterface

// file: verilog/capture_buffer.sv
// analyser capture buffer: fills from index zero upward until full
`timescale 1ns/10ps
module capture_buffer #(
  parameter int DEPTH = 32
) (
  input wire logic   aclk,
  input wire logic   aresetn,
  capture_if.store   cap
);
  localparam int IW = $clog2(DEPTH);

  logic [7:0]  mem [DEPTH];
  logic [IW:0] fill;

  // -------------------------------------------------------------------------
  // fill pointer
  // -------------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn || cap.restart)
      fill <= '0;
    else if (cap.wr_valid && !fill[IW])
      fill <= fill + 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (cap.wr_valid && !fill[IW])
      mem[fill[IW-1:0]] <= cap.wr_byte;
  end

  assign cap.full    = fill[IW];
  assign cap.rd_byte = mem[cap.rd_index];

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  fill_order_a: assert property (cap.wr_valid && !fill[IW] && !cap.restart |=>
    fill == $past(fill) + 1'b1 && mem[$past(fill[IW-1:0])] == $past(cap.wr_byte))
    else $error("capture byte not stored at next index");

  fill_hold_a: assert property (fill[IW] && !cap.restart |=> fill[IW])
    else $error("full buffer lost its level without restart");
endmodule

// file: test/framer_array_model.sv
// framer array model: per-framer register store behind the decode strobes
`timescale 1ns/10ps
module framer_array_model (
  input  wire logic         aclk,
  input  wire logic [7:0]   fr_wr_en,
  input  wire logic [7:0]   fr_wr_addr,
  input  wire logic [15:0]  fr_wdata,
  input  wire logic [1:0]   fr_wstrb,
  input  wire logic [7:0]   fr_rd_en,
  input  wire logic [7:0]   fr_rd_addr,
  output logic      [127:0] fr_rdata
);
  logic [15:0] mem [8][256];

  always_ff @(posedge aclk)
  begin
    for (int g = 0; g < 8; g++)
    begin
      // each lane lands only under its own strobe
      if (fr_wr_en[g] && fr_wstrb[0])
        mem[g][fr_wr_addr][7:0] <= fr_wdata[7:0];
      if (fr_wr_en[g] && fr_wstrb[1])
        mem[g][fr_wr_addr][15:8] <= fr_wdata[15:8];
    end
  end

  // an unselected framer shows the inverse, so a stale value never passes
  always_comb
  begin
    for (int g = 0; g < 8; g++)
      fr_rdata[16*g+:16] = fr_rd_en[g] ? mem[g][fr_rd_addr] : ~mem[g][fr_rd_addr];
  end
endmodule

// file: test/testbench.sv
// self-checking bench for the framer global register decode
`timescale 1ns/10ps
module testbench;
  localparam logic [12:0] PART = 13'h0a5c; // arbitrary value
  localparam logic [2:0]  REV  = 3'h5;     // arbitrary value
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0, irq;
  logic [13:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [7:0] sync_i = '0, line_i = '0, elas_i = '0, stream_valid = '0;
  logic [7:0] fr_wr_en, fr_wr_addr, fr_rd_en, fr_rd_addr;
  logic [15:0] fr_wdata, ctrl0, ctrl1, loopb;
  logic [1:0] bresp, rresp, fr_wstrb;
  logic [63:0] stream_byte = '0;
  logic [127:0] fr_rdata;
  logic awready, wready, bvalid, arready, rvalid;
  int errors = 0, samples_checked = 0, cnt = 0;

  always #10 aclk = ~aclk;

  framer_global_register_decode #(.PART_NUMBER(PART), .REVISION(REV))
    u_framer_global_register_decode (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'h3), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1), .fr_wr_en(fr_wr_en),
    .fr_wr_addr(fr_wr_addr), .fr_wdata(fr_wdata), .fr_wstrb(fr_wstrb),
    .fr_rd_en(fr_rd_en), .fr_rd_addr(fr_rd_addr),
    .fr_rdata(fr_rdata), .framer_sync_int(sync_i), .framer_line_int(line_i),
    .framer_elastic_int(elas_i), .framer_hdlc_int(8'h00), .stream_byte(stream_byte),
    .stream_valid(stream_valid), .global_control_zero(ctrl0), .global_control_one(ctrl1),
    .framer_loopback_global(loopb), .irq(irq));

  framer_array_model u_framer_array_model (.aclk(aclk), .fr_wr_en(fr_wr_en),
    .fr_wr_addr(fr_wr_addr), .fr_wdata(fr_wdata), .fr_wstrb(fr_wstrb), .fr_rd_en(fr_rd_en),
    .fr_rd_addr(fr_rd_addr), .fr_rdata(fr_rdata));

  // ----------------------------------------
  // bus tasks and comparison
  // ----------------------------------------
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [11:0] i, input logic [15:0] d);
    int n;
    awaddr <= {i, 2'h0};
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    n = 0;
    // the first look is after an edge, so a response left from the last write is not taken
    do
    begin
      @(posedge aclk);
      n++;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (n < 50 && !bvalid);
    if (!bvalid)
    begin
      errors++;
      end_sim();
    end
    else
      chk(bresp, framer_global_pkg::RESP_OKAY);
  endtask

  task automatic rc(input logic [11:0] i, input logic [31:0] e);
    int n;
    araddr <= {i, 2'h0};
    arvalid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (n < 50 && !arready);
    arvalid <= 1'b0;
    for (n = 0; n < 50 && !rvalid; n++)
      @(posedge aclk);
    if (!rvalid)
    begin
      errors++;
      end_sim();
    end
    else
    begin
      chk(rresp, framer_global_pkg::RESP_OKAY);
      chk(rdata, e);
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    for (int k = 0; k < 6; k++) rc(12'h900 + k, 0);
    rc(framer_global_pkg::IDX_ID, {16'h0000, PART, REV});
    rc(12'h906, 0);
    rc(12'h940, 0);
    rc(12'hfff, 0);
  endtask

  task automatic t_rw();
    for (int k = 0; k < 6; k++) wr(12'h900 + k, 16'h5a30 + k);
    for (int k = 0; k < 6; k++) rc(12'h900 + k, 16'h5a30 + k);
    chk({ctrl0, ctrl1}, 32'h5a305a31);
    chk(loopb, 16'h5a34);
    wr(framer_global_pkg::IDX_ID, 16'h0000);
    rc(framer_global_pkg::IDX_ID, {16'h0000, PART, REV});
    wr(12'h910, 16'hffff);
    rc(12'h910, 0);
    wr(12'h940, 16'hffff);
    rc(12'h900, 16'h5a30);
    for (int k = 0; k < 6; k++) wr(12'h900 + k, 0);
  endtask

  task automatic t_framer();
    for (int g = 0; g < 8; g++) wr({g[3:0], 8'h20}, {g[7:0], 8'h3c});
    for (int g = 0; g < 8; g++) rc({g[3:0], 8'h20}, {g[7:0], 8'h3c});
    wr(12'h8aa, 16'hbeef);
    for (int g = 0; g < 8; g++) rc({g[3:0], 8'haa}, 16'hbeef);
    rc(12'h8aa, 0);
  endtask

  task automatic t_vector();
    {sync_i, line_i, elas_i} <= {3{8'h10}};
    rc(framer_global_pkg::IDX_VEC_HIGH, 7);
    rc(framer_global_pkg::IDX_VEC_LOW, 0);
    chk(irq, 1);
    for (int j = 0; j < 3; j++)
    begin
      wr(framer_global_pkg::IDX_MASK_HIGH, 16'h0001 << j);
      rc(framer_global_pkg::IDX_VEC_HIGH, 7 & ~(1 << j));
    end
    wr(framer_global_pkg::IDX_MASK_HIGH, 7);
    repeat (3) @(posedge aclk);
    chk(irq, 0);
    {sync_i, line_i, elas_i} <= '0;
    wr(framer_global_pkg::IDX_MASK_HIGH, 0);
  endtask

  task automatic push(input int n);
    for (int k = 0; k < n; k++)
    begin
      stream_valid <= 8'hff;
      for (int g = 0; g < 8; g++) stream_byte[8*g+:8] <= {g[2:0], cnt[4:0]};
      cnt++;
      @(posedge aclk);
    end
    stream_valid <= 8'h00;
  endtask

  task automatic t_capture();
    wr(framer_global_pkg::IDX_CTRL1, 16'h000d);
    push(31);
    repeat (5) @(posedge aclk);
    rc(framer_global_pkg::IDX_ANA_STAT, 0);
    push(3);
    repeat (5) @(posedge aclk);
    rc(framer_global_pkg::IDX_ANA_STAT, 1);
    chk(irq, 1);
    wr(framer_global_pkg::IDX_ANA_MASK, 1);
    repeat (3) @(posedge aclk);
    chk(irq, 0);
    for (int k = 0; k < 32; k++) rc(12'h920 + k, {3'h5, k[4:0]});
    wr(framer_global_pkg::IDX_ANA_STAT, 1);
    rc(framer_global_pkg::IDX_ANA_STAT, 0);
  endtask

  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_rw();
    t_framer();
    t_vector();
    t_capture();
    end_sim();
  end
endmodule
